/* File: pkg/uart_frame_pkg.sv */
/*
  Constants, field positions and state types of the serial frame control block.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package uart_frame_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [4:0] STATUS_OFS = 5'h00;
  localparam logic [4:0] CTRL_ONE_OFS = 5'h04;
  localparam logic [4:0] CTRL_TWO_OFS = 5'h08;
  localparam logic [4:0] DATA_OFS = 5'h0c;
  localparam logic [4:0] DIVISOR_OFS = 5'h10;
  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
  localparam logic [7:0] DIVISOR_RESET = 8'h00;
  // ----------------------------------------------------------------
  // Control one fields
  // ----------------------------------------------------------------
  localparam int GLOBAL_EN_BIT = 7;
  localparam int WORD_LEN_BIT = 6;
  localparam int PARITY_EN_BIT = 5;
  localparam int PARITY_TYPE_BIT = 4;
  localparam int STOP_SEL_BIT = 3;
  localparam int BREAK_BIT = 2;
  localparam int RX_NINTH_BIT = 1;
  localparam int TX_NINTH_BIT = 0;
  // ----------------------------------------------------------------
  // Control two fields
  // ----------------------------------------------------------------
  localparam int TX_EN_BIT = 7;
  localparam int RX_EN_BIT = 6;
  localparam int SPEED_BIT = 5;
  localparam int ADDR_DET_BIT = 4;
  localparam int RX_IRQ_EN_BIT = 2;
  // ----------------------------------------------------------------
  // Baud and frame timing
  // ----------------------------------------------------------------
  localparam logic [3:0] LAST_TICK = 4'hf;
  localparam logic [3:0] MID_TICK = 4'h7;
  localparam logic [1:0] LOW_SPEED_LAST = 2'h3;
  localparam logic [3:0] BREAK_BITS = 4'hd;
  localparam logic [3:0] LAST_BIT_EIGHT = 4'h7;
  localparam logic [3:0] LAST_BIT_NINE = 4'h8;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP, TX_BREAK} tx_state_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;
endpackage : uart_frame_pkg

/* File: logic/uart_frame_control.sv */
/*
  Serial transceiver frame control with an Avalon-MM register slave.
  Assumes the receive input is synchronous to clock and idles high.
*/
// Our own choices: the address map and the Avalon-MM register port.
// Summary of operation
// - Global disable empties data buffers and restarts the baud counter.
// - Global disable clears transmit and receive enables, break and error flags; idle flags read set.
// - Global disable keeps all other settings so re-enable resumes them.
// - Clearing global enable aborts any frame in progress, then resets.
// - Word length select picks eight or nine data bits.
// - Parity bit is generated and checked only when parity is enabled.
// - Parity type zero is even, one is odd, both directions.
// - Stop select sends one stop bit when zero, two when one.
// - Break sends buffered data, then holds line low 13 bits until cleared.
// - Received ninth bit is readable; unused in eight-bit mode.
// - Written ninth bit is sent as ninth data bit in nine-bit mode.
// - Transmitter disable aborts, flushes transmit buffer and floats the pin.
// - Transmit pin driven only with transmitter and global enable set.
// - Receiver disable aborts reception and resets receive buffer.
// - Receiver works only with receiver and global enable set.
// - Speed select chooses high or low speed baud generation.
// - Bit rate is clock over 64 or 16 times divisor plus one.
// - Frame is start, data LSB first, optional parity, stop bits.
// - Address bit is data bit 7 or the ninth bit in nine-bit mode.
// - Receive request raised for each address word when enabled.
// - With address detect, words with address bit zero are dropped.
`timescale 1ns/1ps
module uart_frame_control #(
  parameter int DATA_W = 32
) (
  input wire logic clock, // System clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic [4:0] address, // Byte address
  input wire logic read, // Read request
  input wire logic write, // Write request
  input wire logic [DATA_W-1:0] writedata, // Write data
  input wire logic [3:0] byteenable, // Byte lanes
  output logic [DATA_W-1:0] readdata, // Read data
  output logic waitrequest, // Stall
  input wire logic rxIn, // Receive line
  output logic txOut, // Transmit line level
  output logic txOe, // Transmit line enable
  output logic rxIrq // Receive request
);
  import uart_frame_pkg::*;

  if (DATA_W != 32) begin : g_check
    $error("uart_frame_control needs DATA_W of 32");
  end

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rstPipe_reg;
  logic rstn;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) rstPipe_reg <= 2'h0;
    else rstPipe_reg <= {rstPipe_reg[0], 1'b1};
  end
  assign rstn = rstPipe_reg[1];

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic ack_reg, doWrite, doRead, lane0;
  logic [7:0] ctrlOne_reg, ctrlTwo_reg, divisor_reg, status;
  logic [7:0] txHold_reg, rxData_reg;
  logic txNinth_reg, rxNinth_reg, txFull_reg, rxAvail_reg;
  logic overrun_reg, framing_error_flag_reg, parity_error_flag_reg, noise_reg;
  tx_state_t txState;
  rx_state_t rxState;
  logic gen, txRun, rxRun, wlen;

  // One wait cycle per access
  assign waitrequest = (read | write) & ~ack_reg;
  assign doWrite = write & ack_reg;
  assign doRead = read & ack_reg;
  assign lane0 = byteenable[0];
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) ack_reg <= 1'b0;
    else ack_reg <= (read | write) & ~ack_reg;
  end

  assign gen = ctrlOne_reg[GLOBAL_EN_BIT];
  assign wlen = ctrlOne_reg[WORD_LEN_BIT];
  assign txRun = gen & ctrlTwo_reg[TX_EN_BIT];
  assign rxRun = gen & ctrlTwo_reg[RX_EN_BIT];
  assign status = {parity_error_flag_reg, noise_reg, framing_error_flag_reg, overrun_reg,
                   rxState == RX_IDLE, rxAvail_reg,
                   !txFull_reg && txState == TX_IDLE, !txFull_reg};

  // Read data captured in the wait cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) readdata <= '0;
    else if (read & ~ack_reg) begin
      readdata <= '0;
      if (address == STATUS_OFS) readdata[7:0] <= status;
      else if (address == CTRL_ONE_OFS) begin
        readdata[7:0] <= {ctrlOne_reg[7:2], rxNinth_reg, 1'b0};
      end else if (address == CTRL_TWO_OFS) readdata[7:0] <= ctrlTwo_reg;
      else if (address == DATA_OFS) readdata[7:0] <= rxData_reg;
      else if (address == DIVISOR_OFS) readdata[7:0] <= divisor_reg;
    end
  end

  // Control one; disable drops break, keeps the rest
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) ctrlOne_reg <= CTRL_ONE_RESET;
    else begin
      if (doWrite && lane0 && address == CTRL_ONE_OFS) ctrlOne_reg <= writedata[7:0];
      if (!gen) ctrlOne_reg[BREAK_BIT] <= 1'b0;
    end
  end

  // Ninth transmit bit, write only
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) txNinth_reg <= 1'b0;
    else if (doWrite && lane0 && address == CTRL_ONE_OFS) begin
      txNinth_reg <= writedata[TX_NINTH_BIT];
    end
  end

  // Control two; disable drops both direction enables
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) ctrlTwo_reg <= CTRL_TWO_RESET;
    else begin
      if (doWrite && lane0 && address == CTRL_TWO_OFS) ctrlTwo_reg <= writedata[7:0];
      if (!gen) begin
        ctrlTwo_reg[TX_EN_BIT] <= 1'b0;
        ctrlTwo_reg[RX_EN_BIT] <= 1'b0;
      end
    end
  end

  // Divisor, untouched by disable
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) divisor_reg <= DIVISOR_RESET;
    else if (doWrite && lane0 && address == DIVISOR_OFS) divisor_reg <= writedata[7:0];
  end

  // ----------------------------------------------------------------
  // Baud generator: sixteen ticks per bit
  // ----------------------------------------------------------------
  logic [1:0] pre_reg;
  logic [7:0] baudCnt_reg;
  logic preHit, tick;
  assign preHit = ctrlTwo_reg[SPEED_BIT] || pre_reg == LOW_SPEED_LAST;
  assign tick = preHit && baudCnt_reg == divisor_reg;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pre_reg <= 2'h0;
      baudCnt_reg <= 8'h00;
    end else if (!gen) begin
      pre_reg <= 2'h0;
      baudCnt_reg <= 8'h00;
    end else begin
      pre_reg <= preHit ? 2'h0 : pre_reg + 2'h1;
      if (preHit) baudCnt_reg <= tick ? 8'h00 : baudCnt_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  logic [8:0] txShift_reg;
  logic [3:0] txTick_reg, txBit_reg, lastBit;
  logic txOut_reg, txLoad, txBitEnd, txParity_reg;
  assign lastBit = wlen ? LAST_BIT_NINE : LAST_BIT_EIGHT;
  assign txLoad = txRun && txState == TX_IDLE && txFull_reg && tick; // Start bit a full bit
  assign txBitEnd = tick && txTick_reg == LAST_TICK;
  assign txOut = txOut_reg;
  assign txOe = txRun;

  // Holding buffer: write sets, shift load empties
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      txFull_reg <= 1'b0;
      txHold_reg <= 8'h00;
    end else if (!txRun) txFull_reg <= 1'b0;
    else if (doWrite && lane0 && address == DATA_OFS) begin
      txFull_reg <= 1'b1;
      txHold_reg <= writedata[7:0];
    end else if (txLoad) txFull_reg <= 1'b0;
  end

  // Frame sequencer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      txState <= TX_IDLE;
      txOut_reg <= 1'b1;
      txTick_reg <= 4'h0;
      txBit_reg <= 4'h0;
      txShift_reg <= 9'h000;
      txParity_reg <= 1'b0;
    end else if (!txRun) begin
      txState <= TX_IDLE;
      txOut_reg <= 1'b1;
      txTick_reg <= 4'h0;
      txBit_reg <= 4'h0;
    end else begin
      if (tick) txTick_reg <= txTick_reg + 4'h1;
      case (txState)
        TX_IDLE: begin
          txTick_reg <= 4'h0;
          txBit_reg <= 4'h0;
          if (txLoad) begin
            txShift_reg <= {wlen & txNinth_reg, txHold_reg};
            txParity_reg <= ^{wlen & txNinth_reg, txHold_reg}
                            ^ ctrlOne_reg[PARITY_TYPE_BIT];
            txOut_reg <= 1'b0;
            txState <= TX_START;
          end else if (ctrlOne_reg[BREAK_BIT] && !txFull_reg && tick) begin
            txOut_reg <= 1'b0;
            txState <= TX_BREAK;
          end
        end
        TX_START: begin
          if (txBitEnd) begin
            txOut_reg <= txShift_reg[0];
            txState <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (txBitEnd) begin
            txShift_reg <= {1'b0, txShift_reg[8:1]};
            txBit_reg <= txBit_reg + 4'h1;
            if (txBit_reg == lastBit) begin
              txBit_reg <= 4'h0;
              if (ctrlOne_reg[PARITY_EN_BIT]) begin
                txOut_reg <= txParity_reg;
                txState <= TX_PARITY;
              end else begin
                txOut_reg <= 1'b1;
                txState <= TX_STOP;
              end
            end else txOut_reg <= txShift_reg[1];
          end
        end
        TX_PARITY: begin
          if (txBitEnd) begin
            txOut_reg <= 1'b1;
            txState <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (txBitEnd) begin
            if (txBit_reg == 4'h0 && ctrlOne_reg[STOP_SEL_BIT]) txBit_reg <= 4'h1;
            else txState <= TX_IDLE;
          end
        end
        TX_BREAK: begin
          if (txBitEnd && txBit_reg != BREAK_BITS) txBit_reg <= txBit_reg + 4'h1;
          if (txBit_reg == BREAK_BITS && !ctrlOne_reg[BREAK_BIT]) begin
            txOut_reg <= 1'b1;
            txState <= TX_IDLE;
          end
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  logic [8:0] rxShift_reg;
  logic [3:0] rxTick_reg, rxBit_reg;
  logic [2:0] samp_reg;
  logic rxPrev_reg, rxDone_reg, rxPerrPend_reg, rxFerrPend_reg, rxNoisePend_reg;
  logic rxParity_reg, rxBitEnd, vote, noisy, addrBit, accept;
  logic [7:0] rxWord;
  logic rxWordNinth;
  assign rxBitEnd = tick && rxTick_reg == LAST_TICK;
  assign vote = (samp_reg[0] & samp_reg[1]) | (samp_reg[0] & samp_reg[2])
              | (samp_reg[1] & samp_reg[2]);
  assign noisy = !(&samp_reg) && |samp_reg;
  assign rxWord = wlen ? rxShift_reg[7:0] : rxShift_reg[8:1];
  assign rxWordNinth = wlen & rxShift_reg[8];
  assign addrBit = wlen ? rxWordNinth : rxWord[7];
  assign accept = rxDone_reg && (!ctrlTwo_reg[ADDR_DET_BIT] || addrBit);

  // Bit sampler and frame sequencer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxState <= RX_IDLE;
      rxPrev_reg <= 1'b1;
      rxTick_reg <= 4'h0;
      rxBit_reg <= 4'h0;
      samp_reg <= 3'h7;
      rxShift_reg <= 9'h000;
      rxParity_reg <= 1'b0;
      rxDone_reg <= 1'b0;
      rxPerrPend_reg <= 1'b0;
      rxFerrPend_reg <= 1'b0;
      rxNoisePend_reg <= 1'b0;
    end else if (!rxRun) begin
      rxState <= RX_IDLE;
      rxPrev_reg <= 1'b1;
      rxDone_reg <= 1'b0;
    end else begin
      rxPrev_reg <= rxIn;
      rxDone_reg <= 1'b0;
      if (tick) rxTick_reg <= rxTick_reg + 4'h1;
      if (tick && rxTick_reg >= MID_TICK && rxTick_reg <= MID_TICK + 4'h2) begin
        samp_reg <= {samp_reg[1:0], rxIn};
      end
      if (rxBitEnd && rxState != RX_IDLE && noisy) rxNoisePend_reg <= 1'b1;
      case (rxState)
        RX_IDLE: begin
          rxTick_reg <= 4'h0;
          rxBit_reg <= 4'h0;
          if (rxPrev_reg && !rxIn) begin
            rxNoisePend_reg <= 1'b0;
            rxParity_reg <= ctrlOne_reg[PARITY_TYPE_BIT];
            rxState <= RX_START;
          end
        end
        RX_START: begin
          if (rxBitEnd) rxState <= vote ? RX_IDLE : RX_DATA;
        end
        RX_DATA: begin
          if (rxBitEnd) begin
            rxShift_reg <= {vote, rxShift_reg[8:1]};
            rxParity_reg <= rxParity_reg ^ vote;
            rxBit_reg <= rxBit_reg + 4'h1;
            if (rxBit_reg == lastBit) begin
              rxState <= ctrlOne_reg[PARITY_EN_BIT] ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: begin
          if (rxBitEnd) begin
            rxParity_reg <= rxParity_reg ^ vote;
            rxState <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rxBitEnd) begin
            rxPerrPend_reg <= ctrlOne_reg[PARITY_EN_BIT] & rxParity_reg;
            rxFerrPend_reg <= !vote;
            rxDone_reg <= 1'b1;
            rxState <= RX_IDLE;
          end
        end
        default: rxState <= RX_IDLE;
      endcase
    end
  end

  // Receive buffer and flags; a new word wins over a read clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxAvail_reg <= 1'b0;
      overrun_reg <= 1'b0;
      framing_error_flag_reg <= 1'b0;
      parity_error_flag_reg <= 1'b0;
      noise_reg <= 1'b0;
      rxData_reg <= 8'h00;
      rxNinth_reg <= 1'b0;
    end else if (!rxRun) begin
      rxAvail_reg <= 1'b0;
      overrun_reg <= 1'b0;
      framing_error_flag_reg <= 1'b0;
      parity_error_flag_reg <= 1'b0;
      noise_reg <= 1'b0;
    end else begin
      if (doRead && address == DATA_OFS) begin
        rxAvail_reg <= 1'b0;
        overrun_reg <= 1'b0;
        framing_error_flag_reg <= 1'b0;
        parity_error_flag_reg <= 1'b0;
        noise_reg <= 1'b0;
      end
      if (accept) begin
        if (rxAvail_reg && !(doRead && address == DATA_OFS)) overrun_reg <= 1'b1;
        else begin
          rxAvail_reg <= 1'b1;
          rxData_reg <= rxWord;
          rxNinth_reg <= rxWordNinth;
          framing_error_flag_reg <= rxFerrPend_reg;
          parity_error_flag_reg <= rxPerrPend_reg;
          noise_reg <= rxNoisePend_reg;
        end
      end
    end
  end

  assign rxIrq = ctrlTwo_reg[RX_IRQ_EN_BIT] & (rxAvail_reg | overrun_reg);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence sDisable;
    $fell(gen);
  endsequence
  sequence sCleared;
    !ctrlTwo_reg[TX_EN_BIT] && !ctrlTwo_reg[RX_EN_BIT] && !ctrlOne_reg[BREAK_BIT];
  endsequence

  a_disable_flush: assert property (@(posedge clock) disable iff (!rstn)
    sDisable |-> ##1 (!txFull_reg && !rxAvail_reg && baudCnt_reg == 8'h00))
    else $error("disable did not flush");
  a_disable_clears: assert property (@(posedge clock) disable iff (!rstn)
    sDisable |-> ##1 sCleared ##0 (status == 8'h0b))
    else $error("disable did not clear flags");
  a_disable_keeps: assert property (@(posedge clock) disable iff (!rstn)
    (!gen && !write) |=> $stable(divisor_reg) && $stable(ctrlTwo_reg[SPEED_BIT]))
    else $error("disable altered settings");
  a_tx_abort: assert property (@(posedge clock) disable iff (!rstn)
    !txRun |-> !txOe ##1 (txState == TX_IDLE && txOut_reg))
    else $error("transmitter not reset");
  a_rx_abort: assert property (@(posedge clock) disable iff (!rstn)
    !rxRun |=> (rxState == RX_IDLE && !rxAvail_reg))
    else $error("receiver not reset");
  a_break_low: assert property (@(posedge clock) disable iff (!rstn)
    (txState == TX_BREAK ##1 txState != TX_BREAK && txRun)
    |-> $past(txBit_reg) == BREAK_BITS && !$past(txOut_reg))
    else $error("break too short");
  a_stop_two: assert property (@(posedge clock) disable iff (!rstn)
    (txState == TX_STOP && txBit_reg == 4'h1) |-> ctrlOne_reg[STOP_SEL_BIT])
    else $error("second stop bit without select");
  a_addr_drop: assert property (@(posedge clock) disable iff (!rstn)
    (rxDone_reg && ctrlTwo_reg[ADDR_DET_BIT] && !addrBit) |=> !$rose(rxAvail_reg))
    else $error("data word not dropped");
  a_bus_answer: assert property (@(posedge clock) disable iff (!rstn)
    ((read || write) && waitrequest) |=> !waitrequest)
    else $error("bus answer late");
endmodule : uart_frame_control

/* File: tb/serial_peer.sv */
/*
  Remote serial peer: drives the block's receive line, decodes its transmit line.
  Assumes clock-synchronous bits of len cycles and a pulled-up transmit pin.
*/
`timescale 1ns/1ps
module serial_peer (
  input wire logic clock, // System clock
  input wire logic txLine, // Transmit pin level
  output logic lineOut // Receive line into the block
);
  int len = 16;
  int n = 8;
  bit pe = 1'b0;
  int cyc = 0;
  int last = 0;
  logic [10:0] seen[$];
  int gaps[$];
  initial lineOut = 1'b1;
  // Cycle count for start-to-start spacing
  always @(posedge clock) cyc <= cyc + 1;
  // One frame: start, data LSB first, parity, one stop
  task automatic send(int ln, int nb, bit p, bit po, bit bad, logic [8:0] v);
    logic b;
    for (int i = 0; i < nb + p + 2; i++) begin
      if (i == 0) b = 1'b0;
      else if (i <= nb) b = v[i-1];
      else if (p && i == nb + 1) b = ^(v & ((9'h1 << nb) - 9'h1)) ^ po ^ bad;
      else b = 1'b1;
      lineOut <= b;
      repeat (ln) @(posedge clock);
    end
    // Idle gap so the word is stored when the task returns
    repeat (4) @(posedge clock);
  endtask : send
  // Decode each frame mid-bit, start bit first, stop bit last
  initial forever begin : watch
    logic [10:0] w;
    @(negedge txLine);
    @(posedge clock);
    gaps.push_back(cyc - last);
    last = cyc;
    w = '0;
    repeat (len / 2 - 1) @(posedge clock);
    for (int i = 0; i < n + pe + 2; i++) begin
      if (i > 0) repeat (len) @(posedge clock);
      w[i] = txLine;
    end
    seen.push_back(w);
  end
endmodule : serial_peer

/* File: tb/uart_frame_control_bench.sv */
/*
  Self-checking bench of the serial frame control block.
  Assumes the peer model serial_peer and the package uart_frame_pkg.
*/
`timescale 1ns/1ps
module uart_frame_control_bench;
  import uart_frame_pkg::*;
  logic clock = 0, resetn = 0, read = 0, write = 0, rxIn, txOut, txOe, rxIrq, waitrequest;
  logic [4:0] address = '0;
  logic [31:0] writedata = '0, readdata, q;
  logic [3:0] byteenable = '0;
  logic [8:0] d;
  int num_errors = 0, n_compared = 0, lowCnt;
  // Pin pulled up while the block floats it
  wire txPin = txOe ? txOut : 1'b1;
  uart_frame_control uart_frame_control_inst (.clock(clock), .resetn(resetn),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .rxIn(rxIn), .txOut(txOut), .txOe(txOe), .rxIrq(rxIrq));
  serial_peer serial_peer_inst (.clock(clock), .txLine(txPin), .lineOut(rxIn));
  // Clock and hang guard
  initial forever #20 clock = ~clock;
  initial begin
    #1600000;
    num_errors++;
    end_sim();
  end
  task automatic end_sim;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // One bus access, held until waitrequest is seen low
  task automatic acc(bit wr, logic [4:0] a, logic [7:0] v, logic [3:0] be = 4'hf);
    @(posedge clock);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= {24'($urandom), v};
    byteenable <= be;
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : acc
  task automatic wr(logic [4:0] a, logic [7:0] v);
    acc(1, a, v);
  endtask : wr
  task automatic rd(logic [4:0] a, logic [7:0] e, logic [7:0] m = 8'hff);
    acc(0, a, 8'h00);
    chk("readdata", {24'h0, e & m}, q & {24'hffffff, m});
  endtask : rd
  // Expected line word: start, data, parity or stop, stop
  function automatic logic [10:0] frm(logic [8:0] v, int n, bit pe, bit po);
    frm = '0;
    for (int i = 0; i < n; i++) frm[i+1] = v[i];
    frm[n+1] = pe ? (^(v & ((9'h1 << n) - 9'h1)) ^ po) : 1'b1;
    frm[n+1+pe] = 1'b1;
  endfunction : frm
  task automatic take(logic [10:0] e, int eg);
    int g;
    for (int i = 0; i < 4000 && serial_peer_inst.seen.size() == 0; i++) @(posedge clock);
    chk("frame", {21'h0, e}, {21'h0, serial_peer_inst.seen.pop_front()});
    g = serial_peer_inst.gaps.pop_front();
    if (eg > 0) chk("gap", eg, g);
  endtask : take
  // Main sequence
  initial begin
    void'($urandom(32'h2749));
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    rd(STATUS_OFS, 8'h0b);
    rd(CTRL_ONE_OFS, 8'h00, 8'hfd);
    rd(CTRL_TWO_OFS, 8'h00);
    rd(5'h14, 8'h00);
    wr(CTRL_TWO_OFS, 8'he4);
    rd(CTRL_TWO_OFS, 8'h24);
    wr(CTRL_ONE_OFS, 8'h80);
    wr(CTRL_TWO_OFS, 8'he4);
    acc(1, DIVISOR_OFS, 8'h55, 4'he);
    rd(DIVISOR_OFS, 8'h00);
    chk("txOe", 1, txOe);
    // Every transmit format, two frames back to back
    for (int m = 0; m < 16; m++) begin
      d = 9'($urandom);
      serial_peer_inst.n = 8 + m[0];
      serial_peer_inst.pe = m[1];
      wr(CTRL_ONE_OFS, {1'b1, m[0], m[1], m[2], m[3], 2'b00, d[8]});
      wr(DATA_OFS, d[7:0]);
      wr(DATA_OFS, ~d[7:0]);
      take(frm(d, 8 + m[0], m[1], m[2]), -1);
      // Frame length plus the one tick that paces the next load
      take(frm({d[8], ~d[7:0]}, 8 + m[0], m[1], m[2]), (10 + m[0] + m[1] + m[3]) * 16 + 1);
      repeat (40) @(posedge clock);
    end
    // Every receive format, last one with bad parity
    for (int m = 0; m < 8; m++) begin
      d = 9'($urandom);
      wr(CTRL_ONE_OFS, {1'b1, m[0], m[1], m[2], 4'h0});
      serial_peer_inst.send(16, 8 + m[0], m[1], m[2], m == 7, d);
      chk("rxIrq", 1, rxIrq);
      rd(STATUS_OFS, {m == 7, 7'h0f});
      rd(CTRL_ONE_OFS, {7'h0, d[8]} << 1, {6'h0, m[0], 1'b0});
      rd(DATA_OFS, d[7:0]);
      @(posedge clock);
      chk("rxIrq", 0, rxIrq);
    end
    // Address detect, eight then nine bits
    wr(CTRL_ONE_OFS, 8'h80);
    wr(CTRL_TWO_OFS, 8'hf4);
    serial_peer_inst.send(16, 8, 0, 0, 0, 9'h035);
    chk("rxIrq", 0, rxIrq);
    serial_peer_inst.send(16, 8, 0, 0, 0, 9'h0b5);
    chk("rxIrq", 1, rxIrq);
    rd(DATA_OFS, 8'hb5);
    wr(CTRL_ONE_OFS, 8'hc0);
    serial_peer_inst.send(16, 9, 0, 0, 0, 9'h0ff);
    chk("rxIrq", 0, rxIrq);
    serial_peer_inst.send(16, 9, 0, 0, 0, 9'h1a5);
    chk("rxIrq", 1, rxIrq);
    rd(CTRL_ONE_OFS, 8'h02, 8'h02);
    rd(DATA_OFS, 8'ha5);
    // Low speed, divisor one
    wr(CTRL_ONE_OFS, 8'h80);
    wr(DIVISOR_OFS, 8'h01);
    wr(CTRL_TWO_OFS, 8'hc4);
    serial_peer_inst.len = 128;
    serial_peer_inst.n = 8;
    serial_peer_inst.pe = 0;
    wr(DATA_OFS, 8'h3c);
    // Let the first word reach the shifter on its tick
    repeat (16) @(posedge clock);
    wr(DATA_OFS, 8'hc3);
    take(frm(9'h03c, 8, 0, 0), -1);
    // Ten bits of 128 cycles plus one tick of 8 before the next load
    take(frm(9'h0c3, 8, 0, 0), 10 * 128 + 8);
    // Transmitter off, then global off, each in mid-frame
    wr(DATA_OFS, 8'h55);
    repeat (300) @(posedge clock);
    wr(CTRL_TWO_OFS, 8'h44);
    @(posedge clock);
    chk("txOe", 0, txOe);
    rd(STATUS_OFS, 8'h0b);
    wr(CTRL_TWO_OFS, 8'hc4);
    wr(DATA_OFS, 8'h55);
    repeat (300) @(posedge clock);
    wr(CTRL_ONE_OFS, 8'h38);
    @(posedge clock);
    chk("txOe", 0, txOe);
    rd(CTRL_TWO_OFS, 8'h04);
    rd(STATUS_OFS, 8'h0b);
    rd(DIVISOR_OFS, 8'h01);
    rd(CTRL_ONE_OFS, 8'h38, 8'hfd);
    repeat (2000) @(posedge clock);
    serial_peer_inst.seen.delete();
    serial_peer_inst.gaps.delete();
    // Re-enable keeps odd parity and two stop_bit_select
    wr(CTRL_ONE_OFS, 8'hb8);
    wr(CTRL_TWO_OFS, 8'hc4);
    serial_peer_inst.pe = 1;
    wr(DATA_OFS, 8'h71);
    take(frm(9'h071, 8, 1, 1), -1);
    repeat (400) @(posedge clock);
    // Break holds the line low
    wr(CTRL_ONE_OFS, 8'h84);
    lowCnt = 0;
    repeat (14 * 128) begin
      @(posedge clock);
      lowCnt += int'(!txPin);
    end
    chk("break", 1, 32'(lowCnt >= 13 * 128));
    wr(CTRL_ONE_OFS, 8'h80);
    repeat (300) @(posedge clock);
    chk("txPin", 1, txPin);
    end_sim();
  end
endmodule : uart_frame_control_bench
